// ===== inc/fch_defines.vh
// Register offsets, field positions and reset values of the fan override block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef FCH_DEFINES_VH
`define FCH_DEFINES_VH

// Register offsets (byte addresses on the register port)
`define FCH_ADDR_ACOUSTIC   8'h62
`define FCH_ADDR_R1_CRIT    8'h6a
`define FCH_ADDR_LOC_CRIT   8'h6b
`define FCH_ADDR_R2_CRIT    8'h6c
`define FCH_ADDR_R1L_HYST   8'h6d
`define FCH_ADDR_R2_HYST    8'h6e
`define FCH_ADDR_STATUS     8'h70
`define FCH_ADDR_TMIN_R1    8'h71
`define FCH_ADDR_TMIN_LOC   8'h72
`define FCH_ADDR_TMIN_R2    8'h73
`define FCH_ADDR_MIN_ONE    8'h74
`define FCH_ADDR_MIN_TWO    8'h75
`define FCH_ADDR_MIN_THREE  8'h76

// Reset values
`define FCH_RST_CRIT        8'ha4
`define FCH_RST_HYST_R1L    8'h44
`define FCH_RST_HYST_R2     8'h40
`define FCH_RST_ACOUSTIC    8'h00
`define FCH_RST_TMIN        8'h9a
`define FCH_RST_MIN_DUTY    8'h80

// Field positions
`define FCH_HYST_HI_MSB     7
`define FCH_HYST_HI_LSB     4
`define FCH_HYST_LO_MSB     3
`define FCH_HYST_LO_LSB     0
`define FCH_KEEP_ONE_BIT    5
`define FCH_KEEP_TWO_BIT    6
`define FCH_KEEP_THREE_BIT  7

// Duty codes
`define FCH_DUTY_FULL       8'hff
`define FCH_DUTY_OFF        8'h00

`endif

// ===== hdl/fch_hyst_cmp.v
// One temperature channel: hysteretic threshold comparator.
// Assumes temperature, limit and margin share one unsigned code scale.
`timescale 1ns/1ps
`default_nettype none

module fch_hyst_cmp #(
    parameter W = 8
) (
    input  wire         core_clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] temp_i,
    input  wire [W-1:0] limit_i,
    input  wire [3:0]   margin_i,
    output wire         active_o
);
    reg          active_ff;
    reg          nxt_active;
    wire [W:0]   release_lvl;

    // Release point; a margin above the limit borrows into bit W, which holds the state
    assign release_lvl = {1'b0, limit_i} - {{(W-3){1'b0}}, margin_i};

    // Set above limit, clear below limit minus margin; zero margin gives none
    always @* begin
        nxt_active = active_ff;
        if (temp_i > limit_i) begin
            nxt_active = 1'b1;
        end else if (release_lvl[W] || ({1'b0, temp_i} < release_lvl)) begin
            nxt_active = release_lvl[W] ? active_ff : 1'b0;
        end
        if (margin_i == 4'h0 && temp_i <= limit_i) begin
            nxt_active = 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= nxt_active;
        end
    end

    assign active_o = active_ff;
endmodule // fch_hyst_cmp

`default_nettype wire

// ===== hdl/fch_top.v
// Critical-limit override and fan on/off hysteresis for three fan outputs.
// Assumes temperatures and automatic-loop duties arrive synchronous to core_clk_i.
//
// Function
// - Any channel above its critical limit forces every fan output to full duty.
// - The override holds until that channel drops below its limit minus its margin.
// - Margins are 4-bit fields: remote one 7:4 and local 3:0 of 0x6d, remote two 7:4 of 0x6e, 4 by default.
// - Each margin field takes 0 to 15 degrees in one-degree steps.
// - A margin of zero removes hysteresis, so fans may toggle; software should avoid it.
// - The critical override ignores every automatic control setting.
// - Three 8-bit critical limits sit at 0x6a..0x6c and reset to the 100-degree code.
// - A running fan stays on below turn-on until below turn-on minus the margin.
// - One margin per channel serves both fan on/off and override release.
// - Bits 7..5 of 0x62 pick outputs three..one; clear means zero duty below the off point.
// - A set bit keeps that output at its own minimum duty below the off point.
// - For a keep-on output the margin only sets where it drops from loop duty to its minimum duty as temperature falls.
// - The turn-on temperature is where a channel's fan starts under automatic control.
`timescale 1ns/1ps
`default_nettype none
`include "fch_defines.vh"

module fch_top #(
    parameter TW = 8
) (
    input  wire          core_clk_i,
    input  wire          rst_i,
    input  wire [7:0]    reg_addr_i,
    input  wire [7:0]    reg_wdata_i,
    input  wire          reg_wr_i,
    input  wire          reg_rd_i,
    output reg  [7:0]    reg_rdata_o,
    input  wire [TW-1:0] temp_r1_i,
    input  wire [TW-1:0] temp_loc_i,
    input  wire [TW-1:0] temp_r2_i,
    input  wire [7:0]    auto_duty_one_i,
    input  wire [7:0]    auto_duty_two_i,
    input  wire [7:0]    auto_duty_three_i,
    output reg  [7:0]    fan_drive_one_o,
    output reg  [7:0]    fan_drive_two_o,
    output reg  [7:0]    fan_drive_three_o,
    output reg           critical_temp_pin_o
);
    // Timing, temperature to fan:
    //   edge N    comparator state takes the new temperature
    //   edge N+1  fan drives and the override pin take the new state
    // Register writes land at the write edge, so a new limit or margin
    // reaches the comparators on the following edge.

    // Register map on the byte-wide register port:
    //   0x62 keep-on select, bits 7..5 for outputs three..one
    //   0x6a..0x6c critical limits, remote one, local, remote two
    //   0x6d margins, remote one high nibble, local low nibble
    //   0x6e margin, remote two high nibble; low nibble reads zero
    //   0x70 status, read-only: run states 5..3, override states 2..0
    //   0x71..0x73 turn-on temperatures per channel
    //   0x74..0x76 minimum duty per output
    // Unmapped offsets ignore writes and read as zero.

    // Software-visible registers
    reg  [7:0] acoustic_enhance_one_ff;
    reg  [7:0] remote_one_crit_limit_ff;
    reg  [7:0] local_crit_limit_ff;
    reg  [7:0] remote_two_crit_limit_ff;
    reg  [7:0] remote_one_local_hyst_ff;
    reg  [7:0] remote_two_hyst_ff;
    reg  [7:0] tmin_r1_ff;
    reg  [7:0] tmin_loc_ff;
    reg  [7:0] tmin_r2_ff;
    reg  [7:0] min_duty_one_ff;
    reg  [7:0] min_duty_two_ff;
    reg  [7:0] min_duty_three_ff;

    wire [3:0] fan_off_margin_r1;
    wire [3:0] fan_off_margin_loc;
    wire [3:0] fan_off_margin_r2;
    wire       keep_on_out_one;
    wire       keep_on_out_two;
    wire       keep_on_out_three;
    wire [2:0] crit_act;
    wire [2:0] run_act;
    wire       override;
    reg  [7:0] nxt_fan_drive_one;
    reg  [7:0] nxt_fan_drive_two;
    reg  [7:0] nxt_fan_drive_three;

    // Per-channel margin fields, shared by on/off and override release.
    // One field per channel: a single write moves both release points.
    assign fan_off_margin_r1  = remote_one_local_hyst_ff[`FCH_HYST_HI_MSB:`FCH_HYST_HI_LSB];
    assign fan_off_margin_loc = remote_one_local_hyst_ff[`FCH_HYST_LO_MSB:`FCH_HYST_LO_LSB];
    assign fan_off_margin_r2  = remote_two_hyst_ff[`FCH_HYST_HI_MSB:`FCH_HYST_HI_LSB];

    // Keep-on bits; a set bit holds the output at its minimum duty while its channel's run state is off
    assign keep_on_out_one   = acoustic_enhance_one_ff[`FCH_KEEP_ONE_BIT];
    assign keep_on_out_two   = acoustic_enhance_one_ff[`FCH_KEEP_TWO_BIT];
    assign keep_on_out_three = acoustic_enhance_one_ff[`FCH_KEEP_THREE_BIT];

    // Register writes; all fields writable, 0 margin accepted as programmed.
    // Remote two keeps its low nibble at zero, so it always reads back zero.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            acoustic_enhance_one_ff  <= `FCH_RST_ACOUSTIC;
            remote_one_crit_limit_ff <= `FCH_RST_CRIT;
            local_crit_limit_ff      <= `FCH_RST_CRIT;
            remote_two_crit_limit_ff <= `FCH_RST_CRIT;
            remote_one_local_hyst_ff <= `FCH_RST_HYST_R1L;
            remote_two_hyst_ff       <= `FCH_RST_HYST_R2;
            tmin_r1_ff               <= `FCH_RST_TMIN;
            tmin_loc_ff              <= `FCH_RST_TMIN;
            tmin_r2_ff               <= `FCH_RST_TMIN;
            min_duty_one_ff          <= `FCH_RST_MIN_DUTY;
            min_duty_two_ff          <= `FCH_RST_MIN_DUTY;
            min_duty_three_ff        <= `FCH_RST_MIN_DUTY;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `FCH_ADDR_ACOUSTIC:  acoustic_enhance_one_ff  <= reg_wdata_i;
                `FCH_ADDR_R1_CRIT:   remote_one_crit_limit_ff <= reg_wdata_i;
                `FCH_ADDR_LOC_CRIT:  local_crit_limit_ff      <= reg_wdata_i;
                `FCH_ADDR_R2_CRIT:   remote_two_crit_limit_ff <= reg_wdata_i;
                `FCH_ADDR_R1L_HYST:  remote_one_local_hyst_ff <= reg_wdata_i;
                `FCH_ADDR_R2_HYST:   remote_two_hyst_ff       <= {reg_wdata_i[7:4], 4'h0};
                `FCH_ADDR_TMIN_R1:   tmin_r1_ff               <= reg_wdata_i;
                `FCH_ADDR_TMIN_LOC:  tmin_loc_ff              <= reg_wdata_i;
                `FCH_ADDR_TMIN_R2:   tmin_r2_ff               <= reg_wdata_i;
                `FCH_ADDR_MIN_ONE:   min_duty_one_ff          <= reg_wdata_i;
                `FCH_ADDR_MIN_TWO:   min_duty_two_ff          <= reg_wdata_i;
                `FCH_ADDR_MIN_THREE: min_duty_three_ff        <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Critical override comparators, one per channel, direct code compare.
    // A limit below its own margin cannot release on cooling; software
    // should keep every limit more than one margin above zero.
    fch_hyst_cmp #(.W(TW)) u_crit_r1 (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .temp_i     (temp_r1_i),
        .limit_i    (remote_one_crit_limit_ff[TW-1:0]),
        .margin_i   (fan_off_margin_r1),
        .active_o   (crit_act[0])
    );
    fch_hyst_cmp #(.W(TW)) u_crit_loc (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .temp_i     (temp_loc_i),
        .limit_i    (local_crit_limit_ff[TW-1:0]),
        .margin_i   (fan_off_margin_loc),
        .active_o   (crit_act[1])
    );
    fch_hyst_cmp #(.W(TW)) u_crit_r2 (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .temp_i     (temp_r2_i),
        .limit_i    (remote_two_crit_limit_ff[TW-1:0]),
        .margin_i   (fan_off_margin_r2),
        .active_o   (crit_act[2])
    );

    // Fan run state per channel: on above turn-on, off below turn-on minus margin.
    // Same comparator as the override, so both bands behave alike at zero margin.
    fch_hyst_cmp #(.W(TW)) u_run_r1 (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .temp_i     (temp_r1_i),
        .limit_i    (tmin_r1_ff[TW-1:0]),
        .margin_i   (fan_off_margin_r1),
        .active_o   (run_act[0])
    );
    fch_hyst_cmp #(.W(TW)) u_run_loc (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .temp_i     (temp_loc_i),
        .limit_i    (tmin_loc_ff[TW-1:0]),
        .margin_i   (fan_off_margin_loc),
        .active_o   (run_act[1])
    );
    fch_hyst_cmp #(.W(TW)) u_run_r2 (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .temp_i     (temp_r2_i),
        .limit_i    (tmin_r2_ff[TW-1:0]),
        .margin_i   (fan_off_margin_r2),
        .active_o   (run_act[2])
    );

    // Any channel trips all fans; no config bit can mask it
    assign override = |crit_act;

    // Per-output duty select. Outputs one and two follow remote one and local,
    // output three follows remote two; a simple fixed channel map.
    // Priority is fixed: override, then run state, then keep bit. The override
    // sits first so no keep bit or loop duty can hold a fan below full duty.

    // Output one: remote one run state, keep bit 5
    always @* begin
        if (override) begin
            nxt_fan_drive_one = `FCH_DUTY_FULL;
        end else if (run_act[0]) begin
            nxt_fan_drive_one = auto_duty_one_i;
        end else if (keep_on_out_one) begin
            nxt_fan_drive_one = min_duty_one_ff;
        end else begin
            nxt_fan_drive_one = `FCH_DUTY_OFF;
        end
    end

    // Output two: local run state, keep bit 6
    always @* begin
        if (override) begin
            nxt_fan_drive_two = `FCH_DUTY_FULL;
        end else if (run_act[1]) begin
            nxt_fan_drive_two = auto_duty_two_i;
        end else if (keep_on_out_two) begin
            nxt_fan_drive_two = min_duty_two_ff;
        end else begin
            nxt_fan_drive_two = `FCH_DUTY_OFF;
        end
    end

    // Output three: remote two run state, keep bit 7
    always @* begin
        if (override) begin
            nxt_fan_drive_three = `FCH_DUTY_FULL;
        end else if (run_act[2]) begin
            nxt_fan_drive_three = auto_duty_three_i;
        end else if (keep_on_out_three) begin
            nxt_fan_drive_three = min_duty_three_ff;
        end else begin
            nxt_fan_drive_three = `FCH_DUTY_OFF;
        end
    end

    // Registered fan drives and override pin, so every output leaves a flop
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            fan_drive_one_o     <= `FCH_DUTY_OFF;
            fan_drive_two_o     <= `FCH_DUTY_OFF;
            fan_drive_three_o   <= `FCH_DUTY_OFF;
            critical_temp_pin_o <= 1'b0;
        end else begin
            fan_drive_one_o     <= nxt_fan_drive_one;
            fan_drive_two_o     <= nxt_fan_drive_two;
            fan_drive_three_o   <= nxt_fan_drive_three;
            critical_temp_pin_o <= override;
        end
    end

    // Read port: data one cycle after the strobe, zero otherwise.
    // Zero between reads keeps stale values off a shared read bus.
    // Status shows live comparator states, bit 0 remote one up to bit 5.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `FCH_ADDR_ACOUSTIC:  reg_rdata_o <= acoustic_enhance_one_ff;
                `FCH_ADDR_R1_CRIT:   reg_rdata_o <= remote_one_crit_limit_ff;
                `FCH_ADDR_LOC_CRIT:  reg_rdata_o <= local_crit_limit_ff;
                `FCH_ADDR_R2_CRIT:   reg_rdata_o <= remote_two_crit_limit_ff;
                `FCH_ADDR_R1L_HYST:  reg_rdata_o <= remote_one_local_hyst_ff;
                `FCH_ADDR_R2_HYST:   reg_rdata_o <= remote_two_hyst_ff;
                `FCH_ADDR_STATUS:    reg_rdata_o <= {2'b00, run_act, crit_act};
                `FCH_ADDR_TMIN_R1:   reg_rdata_o <= tmin_r1_ff;
                `FCH_ADDR_TMIN_LOC:  reg_rdata_o <= tmin_loc_ff;
                `FCH_ADDR_TMIN_R2:   reg_rdata_o <= tmin_r2_ff;
                `FCH_ADDR_MIN_ONE:   reg_rdata_o <= min_duty_one_ff;
                `FCH_ADDR_MIN_TWO:   reg_rdata_o <= min_duty_two_ff;
                `FCH_ADDR_MIN_THREE: reg_rdata_o <= min_duty_three_ff;
                default:             reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule // fch_top

`default_nettype wire

// ===== tb/fch_top_sva.sv
// Port-level checker for the fan override block.
// Assumes limits change only by writes on the register port.
`timescale 1ns/1ps
`default_nettype none
`include "fch_defines.vh"
module fch_chk #(
    parameter TW = 8
) (
    input wire logic          core_clk_i,
    input wire logic          rst_i,
    input wire logic [7:0]    reg_addr_i,
    input wire logic [7:0]    reg_wdata_i,
    input wire logic          reg_wr_i,
    input wire logic          reg_rd_i,
    input wire logic [7:0]    reg_rdata_o,
    input wire logic [TW-1:0] temp_r1_i,
    input wire logic [TW-1:0] temp_loc_i,
    input wire logic [TW-1:0] temp_r2_i,
    input wire logic [7:0]    fan_drive_one_o,
    input wire logic [7:0]    fan_drive_two_o,
    input wire logic [7:0]    fan_drive_three_o,
    input wire logic          critical_temp_pin_o
);
    logic [7:0] l1_ff, l2_ff, l3_ff;
    logic       hot, cold;
    logic [3:0] m1_ff;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Shadow limits and remote one margin so trip points follow software
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            m1_ff <= 4'h4;
            l1_ff <= `FCH_RST_CRIT;
            l2_ff <= `FCH_RST_CRIT;
            l3_ff <= `FCH_RST_CRIT;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `FCH_ADDR_R1_CRIT) l1_ff <= reg_wdata_i;
            if (reg_addr_i == `FCH_ADDR_R1L_HYST) m1_ff <= reg_wdata_i[7:4];
            if (reg_addr_i == `FCH_ADDR_LOC_CRIT) l2_ff <= reg_wdata_i;
            if (reg_addr_i == `FCH_ADDR_R2_CRIT) l3_ff <= reg_wdata_i;
        end
    end
    // Cold: below every limit by the widest margin, so release is certain
    assign hot  = temp_r1_i > l1_ff || temp_loc_i > l2_ff || temp_r2_i > l3_ff;
    assign cold = temp_r1_i + 9'd15 < l1_ff && temp_loc_i + 9'd15 < l2_ff
               && temp_r2_i + 9'd15 < l3_ff;
    property p_full;
        critical_temp_pin_o |->
            {fan_drive_one_o, fan_drive_two_o, fan_drive_three_o} == 24'hffffff;
    endproperty
    a_full: assert property (p_full) else $error("override not at full duty");
    property p_trip; hot |-> ##2 critical_temp_pin_o; endproperty
    a_trip: assert property (p_trip) else $error("no override above limit");
    property p_hold;
        (temp_r1_i > l1_ff) ##1 (temp_r1_i >= l1_ff && m1_ff != 4'h0)
            |-> ##2 critical_temp_pin_o;
    endproperty
    a_hold: assert property (p_hold) else $error("override released early");
    property p_cool; cold |-> ##2 !critical_temp_pin_o; endproperty
    a_cool: assert property (p_cool) else $error("override not released");
    property p_rd_lim;
        reg_rd_i && reg_addr_i == `FCH_ADDR_R1_CRIT |=> reg_rdata_o == l1_ff;
    endproperty
    a_rd_lim: assert property (p_rd_lim) else $error("limit readback wrong");
    property p_hyst_lo;
        reg_rd_i && reg_addr_i == `FCH_ADDR_R2_HYST |=> reg_rdata_o[3:0] == 4'h0;
    endproperty
    a_hyst_lo: assert property (p_hyst_lo) else $error("unused nibble set");
    property p_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
    property p_unm; reg_rd_i && reg_addr_i == 8'h61 |=> reg_rdata_o == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // fch_chk
bind fch_top fch_chk #(.TW(TW)) fch_chk_i (.*);
`default_nettype wire

// ===== tb/fch_far_side.sv
// Sensor and control-loop side: temperatures and automatic duties.
// Assumes a new conversion is published only on a load strobe.
`timescale 1ns/1ps
`default_nettype none
module fch_far_side (
    input  wire logic            core_clk_i,
    input  wire logic            rst_i,
    input  wire logic            load_i,
    input  wire logic [2:0][7:0] t_i,
    input  wire logic [2:0][7:0] d_i,
    output var  logic [2:0][7:0] tmp_o,
    output var  logic [2:0][7:0] dty_o
);
    // Values hold between conversions, as a real sensor does
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tmp_o <= '0;
            dty_o <= '0;
        end else if (load_i) begin
            tmp_o <= t_i;
            dty_o <= d_i;
        end
    end
endmodule // fch_far_side
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench: random temperature walk against a reference model.
// Assumes fixed two-cycle latency from temperature to fan outputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic            core_clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic [7:0]      reg_addr_i = 8'h00;
    logic [7:0]      reg_wdata_i = 8'h00;
    logic            reg_wr_i = 1'b0;
    logic            reg_rd_i = 1'b0;
    logic            load = 1'b0;
    logic [2:0][7:0] t_set = '0;
    logic [2:0][7:0] d_set = '0;
    wire logic [7:0] reg_rdata_o, fan_drive_one_o, fan_drive_two_o, fan_drive_three_o;
    wire logic [7:0] temp_r1_i, temp_loc_i, temp_r2_i;
    wire logic [7:0] auto_duty_one_i, auto_duty_two_i, auto_duty_three_i;
    wire logic       critical_temp_pin_o;
    logic [2:0]      crit_m, run_m;
    logic [31:0]     seed = 32'hc97d;
    int lim[3] = '{'ha4, 'ha4, 'ha4};
    int ton[3] = '{'h9a, 'h9a, 'h9a};
    int mnd[3] = '{'h80, 'h80, 'h80};
    int hy[3] = '{4, 4, 4};
    int t[3] = '{'h90, 'h90, 'h90};
    int acou = 0;
    int err_total = 0;
    int n_checks = 0;
    int v;
    always #5 core_clk_i = ~core_clk_i;
    fch_top #(.TW(8)) fch_top_i (.*);
    fch_far_side fch_far_side_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .load_i(load),
        .t_i(t_set), .d_i(d_set), .tmp_o({temp_r2_i, temp_loc_i, temp_r1_i}),
        .dty_o({auto_duty_three_i, auto_duty_two_i, auto_duty_one_i}));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic rnd(input int m);
        seed = lfsr(seed);
        v = int'(seed[15:0]) % m;
    endtask
    // Hysteretic comparator; zero margin means no band at all
    function automatic logic hys(input logic st, input int tv, l, m);
        if (tv > l) return 1'b1;
        if (m == 0 || (l >= m && tv < l - m)) return 1'b0;
        return st;
    endfunction
    // Reference state, stepped on the design's own edges
    always @(posedge core_clk_i) begin
        for (int c = 0; c < 3; c++) begin
            crit_m[c] <= rst_i ? 1'b0 : hys(crit_m[c], t_of(c), lim[c], hy[c]);
            run_m[c]  <= rst_i ? 1'b0 : hys(run_m[c], t_of(c), ton[c], hy[c]);
        end
    end
    function automatic int t_of(input int c);
        return c == 0 ? temp_r1_i : c == 1 ? temp_loc_i : temp_r2_i;
    endfunction
    function automatic logic [7:0] exp_drv(input int k);
        if (|crit_m) return 8'hff;
        if (run_m[k]) return fch_far_side_i.dty_o[k];
        return acou[5 + k] ? 8'(mnd[k]) : 8'h00;
    endfunction
    function automatic logic [7:0] rexp(input logic [7:0] a);
        if (a >= 8'h6a && a <= 8'h6c) return 8'(lim[a - 8'h6a]);
        if (a >= 8'h71 && a <= 8'h73) return 8'(ton[a - 8'h71]);
        if (a >= 8'h74 && a <= 8'h76) return 8'(mnd[a - 8'h74]);
        if (a == 8'h6d) return 8'(hy[0] * 16 + hy[1]);
        if (a == 8'h6e) return 8'(hy[2] * 16);
        if (a == 8'h62) return 8'(acou);
        if (a == 8'h70) return {2'b00, run_m, crit_m};
        return 8'h00;
    endfunction
    task automatic check(input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Model updates 1 ns after the write edge, so it never races that edge
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
        if (a >= 8'h6a && a <= 8'h6c) lim[a - 8'h6a] = d;
        if (a >= 8'h71 && a <= 8'h73) ton[a - 8'h71] = d;
        if (a >= 8'h74 && a <= 8'h76) mnd[a - 8'h74] = d;
        if (a == 8'h6d) hy[0] = d[7:4];
        if (a == 8'h6d) hy[1] = d[3:0];
        if (a == 8'h6e) hy[2] = d[7:4];
        if (a == 8'h62) acou = d;
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        e = rexp(a);
        #1 check(reg_rdata_o, e);
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int a = 8'h60; a < 8'h78; a++) rd(8'(a));
        wr(8'h70, 8'hff); // Status is read-only
        wr(8'h6f, 8'ha5);
        rd(8'h70);
        rd(8'h6f);
        for (int s = 0; s < 400; s++) begin
            // Every 50 steps reprogram, including zero and widest margins
            if (s % 50 == 0 && s > 0) begin
                rnd(256);
                wr(8'h6d, s == 100 ? 8'h00 : s == 150 ? 8'hff : 8'(v));
                rnd(256);
                wr(8'h6e, s == 100 ? 8'h0f : 8'(v));
                rnd(256);
                wr(8'h62, 8'(v));
                rnd(16);
                wr(8'h6b, 8'(8'h9c + v));
                rnd(256);
                wr(8'(8'h74 + s % 3), 8'(v));
                rd(8'h6d);
                rd(8'h6e);
            end
            for (int c = 0; c < 3; c++) begin
                rnd(7);
                t[c] = t[c] + v - 3;
                t[c] = t[c] < 'h88 ? 'h88 : t[c] > 'hb8 ? 'hb8 : t[c];
                t_set[c] <= 8'(t[c]);
                rnd(256);
                d_set[c] <= 8'(v);
            end
            load <= 1'b1;
            @(posedge core_clk_i);
            load <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            #1 check(fan_drive_one_o, exp_drv(0));
            check(fan_drive_two_o, exp_drv(1));
            check(fan_drive_three_o, exp_drv(2));
            check({7'h00, critical_temp_pin_o}, {7'h00, |crit_m});
            rd(8'h70);
        end
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
